// ==== logic/alcc_top.sv ====
/*
  level controller configuration and gain stepping: two control registers, the
  threshold lookup and the 0.5 dB gain stepper.
  assumes a byte register port from the serial control decoder, a programmed gain
  from the neighbouring channel gain register, and an asynchronous comparator
  flag from the analog output stage.
*/
`timescale 1ns/1ps
module alcc_top
  import alcc_pkg::*;
#(
  parameter int ATTACK_BASE_CYC  = ALCC_ATTACK_BASE_CYC,
  parameter int RELEASE_BASE_CYC = ALCC_RELEASE_BASE_CYC
)
(
  // clock and reset
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rst_b,
  // register port
  input  wire logic [7:0]             i_reg_addr,
  input  wire logic [7:0]             i_reg_wdata,
  input  wire logic                   i_reg_wr,
  input  wire logic                   i_reg_rd,
  output logic [7:0]                  o_reg_rdata,
  // gain path
  input  wire logic [ALCC_GAIN_W-1:0] i_prog_gain,
  input  wire logic                   i_over_threshold,
  output logic [ALCC_GAIN_W-1:0]      o_gain,
  output logic                        o_gain_wr_lock,
  // configuration to the analog stage
  output logic                        o_level_ctrl_enable,
  output logic [2:0]                  o_release_period_sel,
  output logic [2:0]                  o_attack_period_sel,
  output logic [1:0]                  o_comp_curve,
  output logic                        o_threshold_fixed_power_sel,
  output logic [3:0]                  o_threshold_level_code,
  output logic [ALCC_LIM_W-1:0]       o_threshold_limit
);

  alcc_state_s           st_r;
  alcc_state_s           st_nxt;
  logic                  enable;
  logic                  over;
  logic                  atk_tick;
  logic                  rel_tick;
  logic [ALCC_CNT_W-1:0] atk_period;
  logic [ALCC_CNT_W-1:0] rel_period;

  // field views of the registers
  assign enable     = st_r.cfg[ALCC_EN_BIT];
  assign over       = st_r.over_s2;
  assign atk_period = ALCC_CNT_W'(ATTACK_BASE_CYC) << st_r.timing[ALCC_ATK_MSB:ALCC_ATK_LSB]; // RULE_02
  assign rel_period = ALCC_CNT_W'(RELEASE_BASE_CYC) << st_r.timing[ALCC_REL_MSB:ALCC_REL_LSB]; // RULE_01

  // attack steps only while the output is over the limit
  alcc_step_timer u_attack (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_run     (enable && over),
    .i_period  (atk_period),
    .o_tick    (atk_tick)
  );

  // release steps only while under the limit and below the programmed gain
  alcc_step_timer u_release (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_run     (enable && !over && (st_r.gain < i_prog_gain)),
    .i_period  (rel_period),
    .o_tick    (rel_tick)
  );

  // next state: register writes, reads, comparator sync, gain stepping, limit lookup
  always_comb begin
    st_nxt = st_r;
    // two flops on the comparator; the first is only read by the second
    st_nxt.over_s1 = i_over_threshold;
    st_nxt.over_s2 = st_r.over_s1;

    // register writes; upper timing bits are held at zero
    if (i_reg_wr && (i_reg_addr == ALCC_ADDR_TIMING)) begin
      st_nxt.timing = i_reg_wdata & ALCC_TIMING_WMSK; // RULE_11
    end
    if (i_reg_wr && (i_reg_addr == ALCC_ADDR_CONFIG)) begin
      st_nxt.cfg = i_reg_wdata; // RULE_04 RULE_05 RULE_06
    end

    // reads; unmapped addresses answer zero
    if (i_reg_rd) begin
      case (i_reg_addr)
        ALCC_ADDR_TIMING: st_nxt.rdata = st_r.timing & ALCC_TIMING_WMSK; // RULE_11
        ALCC_ADDR_CONFIG: st_nxt.rdata = st_r.cfg;
        default:          st_nxt.rdata = ALCC_RDATA_NONE;
      endcase
    end

    // gain: follows the programmed value when off, loaded at enable, then stepped
    if (!st_nxt.cfg[ALCC_EN_BIT] || !enable) begin
      st_nxt.gain = i_prog_gain; // RULE_03
    end else if (atk_tick) begin
      if (st_r.gain != '0) begin
        st_nxt.gain = st_r.gain - ALCC_GAIN_W'(1); // RULE_10
      end
    end else if (st_r.gain > i_prog_gain) begin
      st_nxt.gain = i_prog_gain; // RULE_10
    end else if (rel_tick) begin
      st_nxt.gain = st_r.gain + ALCC_GAIN_W'(1); // RULE_10
    end

    // limit follows the next configuration so it never lags the register
    if (st_nxt.cfg[ALCC_FIX_BIT]) begin
      st_nxt.limit = ALCC_CW8_TBL[st_nxt.cfg[ALCC_LVL_MSB:ALCC_LVL_LSB]]; // RULE_08
    end else begin
      st_nxt.limit = ALCC_PCT_TBL[st_nxt.cfg[ALCC_LVL_MSB:ALCC_LVL_LSB]]; // RULE_07
    end
  end

  // state register
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      st_r         <= '0;
      st_r.timing  <= ALCC_TIMING_RST; // RULE_01 RULE_02
      st_r.cfg     <= ALCC_CONFIG_RST; // RULE_03 RULE_06
      st_r.limit   <= ALCC_PCT_DEF;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs
  assign o_reg_rdata                 = st_r.rdata;
  assign o_gain                      = st_r.gain;
  assign o_gain_wr_lock              = enable; // RULE_09
  assign o_level_ctrl_enable         = enable;
  assign o_release_period_sel        = st_r.timing[ALCC_REL_MSB:ALCC_REL_LSB];
  assign o_attack_period_sel         = st_r.timing[ALCC_ATK_MSB:ALCC_ATK_LSB];
  assign o_comp_curve                = st_r.cfg[ALCC_COMP_MSB:ALCC_COMP_LSB];
  assign o_threshold_fixed_power_sel = st_r.cfg[ALCC_FIX_BIT];
  assign o_threshold_level_code      = st_r.cfg[ALCC_LVL_MSB:ALCC_LVL_LSB];
  assign o_threshold_limit           = st_r.limit;

  // checks on the driven outputs
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  a_release_default: assert property (!$past(i_rst_b) |-> o_release_period_sel == ALCC_REL_DEF) // RULE_01
    else $error("release period code not at default after reset");

  a_attack_default: assert property (!$past(i_rst_b) |-> o_attack_period_sel == ALCC_ATK_DEF) // RULE_02
    else $error("attack period code not at default after reset");

  a_enable_loads_gain: assert property ($rose(o_level_ctrl_enable) |-> o_gain == $past(i_prog_gain)) // RULE_03
    else $error("gain not loaded when controller enabled");

  a_enable_reset_off: assert property (!$past(i_rst_b) |-> !o_level_ctrl_enable) // RULE_03
    else $error("controller enabled after reset");

  a_curve_write: assert property ( // RULE_04
      i_reg_wr && i_reg_addr == ALCC_ADDR_CONFIG
      |=> o_comp_curve == $past(i_reg_wdata[ALCC_COMP_MSB:ALCC_COMP_LSB]))
    else $error("compressor curve did not follow write");

  a_mode_write: assert property ( // RULE_05
      i_reg_wr && i_reg_addr == ALCC_ADDR_CONFIG
      |=> o_threshold_fixed_power_sel == $past(i_reg_wdata[ALCC_FIX_BIT]))
    else $error("threshold mode did not follow write");

  a_config_default: assert property ( // RULE_06
      !$past(i_rst_b) |-> o_threshold_level_code == ALCC_LVL_DEF
      && o_comp_curve == ALCC_COMP_DEF && !o_threshold_fixed_power_sel)
    else $error("config fields not at default after reset");

  a_pct_limit: assert property ( // RULE_07
      !o_threshold_fixed_power_sel && o_threshold_level_code == ALCC_LVL_TOP
      |-> o_threshold_limit == ALCC_PCT_TOP)
    else $error("supply tracking limit wrong for top code");

  a_pct_default: assert property ( // RULE_07
      !o_threshold_fixed_power_sel && o_threshold_level_code == ALCC_LVL_DEF
      |-> o_threshold_limit == ALCC_PCT_DEF)
    else $error("supply tracking limit wrong for default code");

  a_power_limit: assert property ( // RULE_08
      o_threshold_fixed_power_sel && o_threshold_level_code == ALCC_LVL_TOP
      |-> o_threshold_limit == ALCC_CW8_TOP)
    else $error("fixed power limit wrong for top code");

  a_gain_lock: assert property (o_gain_wr_lock == o_level_ctrl_enable) // RULE_09
    else $error("gain write lock does not track enable");

  a_attack_step: assert property ( // RULE_10
      o_level_ctrl_enable && atk_tick && o_gain != '0
      && i_reg_addr != ALCC_ADDR_CONFIG |=> o_gain == $past(o_gain) - ALCC_GAIN_W'(1))
    else $error("attack tick did not lower gain one step");

  a_gain_cap: assert property ( // RULE_10
      o_level_ctrl_enable && $past(o_level_ctrl_enable) && $stable(i_prog_gain)
      && $past(o_gain) <= $past(i_prog_gain) |-> o_gain <= i_prog_gain)
    else $error("gain above programmed gain");

  a_timing_upper: assert property ( // RULE_11
      i_reg_rd && i_reg_addr == ALCC_ADDR_TIMING |=> (o_reg_rdata & ~ALCC_TIMING_WMSK) == ALCC_RDATA_NONE)
    else $error("timing register upper bits not zero");

  a_limit_default: assert property (!$past(i_rst_b) |-> o_threshold_limit == ALCC_PCT_DEF) // RULE_07
    else $error("threshold limit not at default after reset");

  // each write lands whole one cycle after its strobe
  a_period_write: assert property ( // RULE_01 RULE_02
      i_reg_wr && i_reg_addr == ALCC_ADDR_TIMING
      |=> o_release_period_sel == $past(i_reg_wdata[ALCC_REL_MSB:ALCC_REL_LSB])
      && o_attack_period_sel == $past(i_reg_wdata[ALCC_ATK_MSB:ALCC_ATK_LSB]))
    else $error("period codes did not follow write");

  a_enable_write: assert property ( // RULE_03
      i_reg_wr && i_reg_addr == ALCC_ADDR_CONFIG
      |=> o_level_ctrl_enable == $past(i_reg_wdata[ALCC_EN_BIT]))
    else $error("enable bit did not follow write");

  a_level_write: assert property ( // RULE_06
      i_reg_wr && i_reg_addr == ALCC_ADDR_CONFIG
      |=> o_threshold_level_code == $past(i_reg_wdata[ALCC_LVL_MSB:ALCC_LVL_LSB]))
    else $error("threshold level code did not follow write");

  // without a config write the fields must stand, whatever else the port does
  a_config_hold: assert property ( // RULE_06
      !(i_reg_wr && i_reg_addr == ALCC_ADDR_CONFIG)
      |=> $stable(o_threshold_level_code) && $stable(o_comp_curve))
    else $error("config fields changed without a write");

  a_gain_tracks_off: assert property (!o_level_ctrl_enable |=> o_gain == $past(i_prog_gain)) // RULE_03
    else $error("gain did not follow programmed gain while disabled");

  a_release_step: assert property ( // RULE_10
      o_level_ctrl_enable && rel_tick && !(i_reg_wr && i_reg_addr == ALCC_ADDR_CONFIG)
      |=> o_gain == $past(o_gain) + ALCC_GAIN_W'(1))
    else $error("release tick did not raise gain one step");

endmodule // alcc_top

// ==== logic/alcc_pkg.sv ====
/*
  constants, field layouts, reset values, lookup tables and state types for the
  automatic level controller configuration block.
  assumes a 10 MHz reference clock and a byte-wide register access port that the
  serial control port decoder presents after it has decoded a transaction.
*/
// What this block does
// RULE_01: release period per 0.5 dB step from bits 5:3, 4 ms doubling to 512 ms, default 101.
// RULE_02: attack period per 0.5 dB step from bits 2:0, 32 us doubling to 4 ms, default 011.
// RULE_03: enable bit 7 loads current gain into the controller; clear after reset.
// RULE_04: compressor curve from bits 6:5: limiter, modes 1, 2 (default), 3.
// RULE_05: bit 4 picks supply tracking (0, default) or fixed output power (1).
// RULE_06: threshold level code from bits 3:0, reset value 1011.
// RULE_07: supply tracking limit rises with code; 1111 is 96 percent, 1011 is 85.
// RULE_08: fixed power limit rises with code; 1111 is 1.19 W into 8 ohm.
// RULE_09: while enabled, host writes to the channel gain field are ignored.
// RULE_10: enabled: step down per attack period when over, up per release, capped.
// RULE_11: the two upper timing register bits read zero and ignore writes.
package alcc_pkg;

  // register addresses on the control port
  localparam logic [7:0] ALCC_ADDR_TIMING = 8'h03;
  localparam logic [7:0] ALCC_ADDR_CONFIG = 8'h04;

  // reset values: release 101, attack 011; enable 0, curve 10, supply tracking, level 1011
  localparam logic [7:0] ALCC_TIMING_RST  = 8'h2B;
  localparam logic [7:0] ALCC_CONFIG_RST  = 8'h4B;
  localparam logic [7:0] ALCC_TIMING_WMSK = 8'h3F;
  localparam logic [7:0] ALCC_RDATA_NONE  = 8'h00;

  // field positions
  localparam int ALCC_REL_MSB  = 5;
  localparam int ALCC_REL_LSB  = 3;
  localparam int ALCC_ATK_MSB  = 2;
  localparam int ALCC_ATK_LSB  = 0;
  localparam int ALCC_EN_BIT   = 7;
  localparam int ALCC_COMP_MSB = 6;
  localparam int ALCC_COMP_LSB = 5;
  localparam int ALCC_FIX_BIT  = 4;
  localparam int ALCC_LVL_MSB  = 3;
  localparam int ALCC_LVL_LSB  = 0;

  // widths
  localparam int ALCC_GAIN_W = 6;
  localparam int ALCC_CNT_W  = 24;
  localparam int ALCC_LIM_W  = 7;

  // timing: base periods for code 000, each code step doubles the period
  localparam int ALCC_CLK_PERIOD_NS   = 100;
  localparam int ALCC_ATTACK_BASE_NS  = 32000;
  localparam int ALCC_RELEASE_BASE_NS = 4000000;
  localparam int ALCC_ATTACK_BASE_CYC =
    (ALCC_ATTACK_BASE_NS + ALCC_CLK_PERIOD_NS - 1) / ALCC_CLK_PERIOD_NS;
  localparam int ALCC_RELEASE_BASE_CYC =
    (ALCC_RELEASE_BASE_NS + ALCC_CLK_PERIOD_NS - 1) / ALCC_CLK_PERIOD_NS;

  // threshold limits indexed by level code: percent of supply, and centiwatts into 8 ohm
  localparam logic [6:0] ALCC_PCT_TBL [16] = '{
    7'h40, 7'h42, 7'h43, 7'h45, 7'h46, 7'h48, 7'h4A, 7'h4C,
    7'h4E, 7'h50, 7'h53, 7'h55, 7'h58, 7'h5A, 7'h5D, 7'h60};
  localparam logic [6:0] ALCC_CW8_TBL [16] = '{
    7'h2A, 7'h2E, 7'h32, 7'h36, 7'h3B, 7'h3F, 7'h44, 7'h49,
    7'h4E, 7'h53, 7'h59, 7'h5F, 7'h64, 7'h6A, 7'h71, 7'h77};
  localparam logic [6:0] ALCC_PCT_TOP = 7'h60;
  localparam logic [6:0] ALCC_PCT_DEF = 7'h55;
  localparam logic [6:0] ALCC_CW8_TOP = 7'h77;
  localparam logic [3:0] ALCC_LVL_TOP = 4'hF;
  localparam logic [3:0] ALCC_LVL_DEF = 4'hB;
  localparam logic [2:0] ALCC_REL_DEF = 3'h5;
  localparam logic [2:0] ALCC_ATK_DEF = 3'h3;
  localparam logic [1:0] ALCC_COMP_DEF = 2'h2;

  // compressor curves
  typedef enum logic [1:0] {
    ALCC_CURVE_LIMIT = 2'h0,
    ALCC_CURVE_COMP1 = 2'h1,
    ALCC_CURVE_COMP2 = 2'h2,
    ALCC_CURVE_COMP3 = 2'h3
  } alcc_curve_e;

  // step timer state
  typedef struct packed {
    logic [ALCC_CNT_W-1:0] count;
  } alcc_tmr_s;

  // top level state
  typedef struct packed {
    logic [7:0]             timing;
    logic [7:0]             cfg;
    logic [ALCC_GAIN_W-1:0] gain;
    logic [ALCC_LIM_W-1:0]  limit;
    logic [7:0]             rdata;
    logic                   over_s1;
    logic                   over_s2;
  } alcc_state_s;

endpackage

// ==== logic/alcc_step_timer.sv ====
/*
  per-step period timer: counts reference clocks while running and pulses once
  per programmed period.
  assumes the period is at least one cycle and changes only between steps.
*/
`timescale 1ns/1ps
module alcc_step_timer
  import alcc_pkg::*;
(
  // clock and reset
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst_b,
  // control
  input  wire logic                  i_run,
  input  wire logic [ALCC_CNT_W-1:0] i_period,
  // output
  output logic                       o_tick
);

  alcc_tmr_s st_r;
  alcc_tmr_s st_nxt;
  logic      at_end;

  // last cycle of the period; the count restarts whenever running stops
  assign at_end = (st_r.count >= (i_period - ALCC_CNT_W'(1)));
  assign o_tick = i_run && at_end;

  // next count
  always_comb begin
    st_nxt = st_r;
    if (!i_run || at_end) begin
      st_nxt.count = '0;
    end else begin
      st_nxt.count = st_r.count + ALCC_CNT_W'(1);
    end
  end

  // state register
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule // alcc_step_timer

// ==== bench/tb.sv ====
/*
  self-checking testbench for alcc_top: register port, field outputs, threshold
  lookup and the gain stepper, against an integer model of the two registers.
  assumes a decoded byte register port and small step base periods.
*/
`timescale 1ns/1ps
module tb;
  import alcc_pkg::*;
  // shortened base periods keep the stepper runs to a few dozen cycles
  localparam int ATK = 4;
  localparam int REL = 8;
  // threshold limits by level code: percent of supply, centiwatts into 8 ohm
  localparam int PCT [16] = '{64, 66, 67, 69, 70, 72, 74, 76, 78, 80, 83, 85, 88, 90, 93, 96};
  localparam int CW8 [16] = '{42, 46, 50, 54, 59, 63, 68, 73, 78, 83, 89, 95, 100, 106, 113, 119};

  logic                   i_ref_clk, i_rst_b, i_reg_wr, i_reg_rd, i_over_threshold;
  logic [7:0]             i_reg_addr, i_reg_wdata, o_reg_rdata;
  logic [ALCC_GAIN_W-1:0] i_prog_gain, o_gain;
  logic                   o_gain_wr_lock, o_level_ctrl_enable, o_threshold_fixed_power_sel;
  logic [2:0]             o_release_period_sel, o_attack_period_sel;
  logic [1:0]             o_comp_curve;
  logic [3:0]             o_threshold_level_code;
  logic [ALCC_LIM_W-1:0]  o_threshold_limit;
  int                     err_total, num_checks, tim_m, cfg_m, pg, n, i;
  int                     exp_q[$];
  logic [7:0]             a;

  alcc_top #(.ATTACK_BASE_CYC(ATK), .RELEASE_BASE_CYC(REL)) dut (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_prog_gain(i_prog_gain),
    .i_over_threshold(i_over_threshold), .o_gain(o_gain), .o_gain_wr_lock(o_gain_wr_lock),
    .o_level_ctrl_enable(o_level_ctrl_enable), .o_release_period_sel(o_release_period_sel),
    .o_attack_period_sel(o_attack_period_sel), .o_comp_curve(o_comp_curve),
    .o_threshold_fixed_power_sel(o_threshold_fixed_power_sel),
    .o_threshold_level_code(o_threshold_level_code), .o_threshold_limit(o_threshold_limit));

  // 10 MHz reference clock
  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  // one compare, counted; mismatches reported at once
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // every configuration output against the register model
  task automatic chk_fields;
    chk(o_release_period_sel, tim_m[5:3]);
    chk(o_attack_period_sel, tim_m[2:0]);
    chk(o_level_ctrl_enable, cfg_m[7]);
    chk(o_gain_wr_lock, cfg_m[7]);
    chk(o_comp_curve, cfg_m[6:5]);
    chk(o_threshold_fixed_power_sel, cfg_m[4]);
    chk(o_threshold_level_code, cfg_m[3:0]);
    chk(o_threshold_limit, cfg_m[4] ? CW8[cfg_m[3:0]] : PCT[cfg_m[3:0]]);
  endtask

  // one-cycle write strobe; the model drops the two upper timing bits
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_reg_addr  <= ad;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b0;
    if (ad == 8'h03) tim_m = d & 8'h3F;
    else if (ad == 8'h04) cfg_m = d;
    @(negedge i_ref_clk);
    chk_fields();
  endtask

  // one-cycle read strobe, data checked in the following cycle
  task automatic rd(input logic [7:0] ad);
    exp_q.push_back(ad == 8'h03 ? tim_m : (ad == 8'h04 ? cfg_m : 0));
    @(posedge i_ref_clk);
    i_reg_addr <= ad;
    i_reg_rd   <= 1'b1;
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b0;
    @(negedge i_ref_clk);
    chk(o_reg_rdata, exp_q.pop_front());
  endtask

  // cycles until the applied gain moves, bounded
  task automatic wait_step(output int k);
    logic [ALCC_GAIN_W-1:0] g;
    g = o_gain;
    k = 0;
    do begin
      @(negedge i_ref_clk);
      k++;
    end while (o_gain === g && k < 300);
  endtask

  // watchdog: the whole run needs well under 5000 cycles
  initial begin
    #500_000;
    err_total++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'h954edcb9));
    {i_reg_wr, i_reg_rd, i_over_threshold, i_rst_b} = 4'h0;
    {i_reg_addr, i_reg_wdata} = 16'h0000;
    i_prog_gain = 6'h22;
    err_total = 0;
    num_checks = 0;
    repeat (16) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    tim_m = 8'h2B;
    cfg_m = 8'h4B;
    @(negedge i_ref_clk);
    chk_fields();
    rd(8'h03);
    rd(8'h04);
    $display("test reset done");
    // every period code, with random junk in the unused upper bits
    for (i = 0; i < 8; i++) begin
      wr(8'h03, {2'($urandom), 3'(i), 3'(7 - i)});
      rd(8'h03);
    end
    $display("test timing done");
    // every level code in both threshold modes, curves cycling
    for (i = 0; i < 32; i++) begin
      wr(8'h04, {1'b0, 2'(i), 1'(i >> 4), 4'(i)});
      rd(8'h04);
    end
    // unmapped places read zero and leave the model untouched
    repeat (4) begin
      a = 8'($urandom);
      if (a == 8'h03 || a == 8'h04) a = 8'h10;
      wr(a, 8'($urandom));
      rd(a);
    end
    $display("test config done");
    // gain stepper with code 001 periods, so the doubling is exercised
    pg = 8 + $urandom % 56;
    @(posedge i_ref_clk);
    i_prog_gain <= 6'(pg);
    wr(8'h03, 8'h09);
    wr(8'h04, 8'hCB);
    chk(o_gain, pg);
    @(posedge i_ref_clk);
    i_over_threshold <= 1'b1;
    wait_step(n);
    chk(o_gain, pg - 1);
    chk(n >= 2 * ATK && n <= 2 * ATK + 4, 1);
    wait_step(n);
    chk(o_gain, pg - 2);
    chk(n >= 2 * ATK && n <= 2 * ATK + 1, 1);
    @(posedge i_ref_clk);
    i_over_threshold <= 1'b0;
    wait_step(n);
    chk(o_gain, pg - 1);
    chk(n >= 2 * REL && n <= 2 * REL + 4, 1);
    wait_step(n);
    chk(o_gain, pg);
    chk(n >= 2 * REL && n <= 2 * REL + 1, 1);
    repeat (3 * REL) @(negedge i_ref_clk);
    chk(o_gain, pg);
    // disabling hands the gain back to the programmed value
    wr(8'h04, 8'h4B);
    pg = $urandom % 64;
    @(posedge i_ref_clk);
    i_prog_gain <= 6'(pg);
    repeat (3) @(negedge i_ref_clk);
    chk(o_gain, pg);
    $display("test stepper done");
    tally_and_finish();
  end
endmodule // tb
